//--- core/cfgsu_top.sv
// Configuration start-up sequencer top
// Contract
// - Start when memory full and count matches
// - Next edge sets first stage of five
// - Stages select done, io, reset release
// - Events ordered freely by option
// - Default io one clock after done
// - Default reset release two after done
// - Readback, scan blocked until three clocks
// - Later stages clocked by config or user
// - Config clock always drives stages zero and one
// - Stage two resyncs to user clock
// - Synced modes feed done pin to stage3
// - Low done pin stalls later progress
// - Free modes ignore done pin level; here only stage 3 does, completion still waits for done high
// - Store length count, count config clocks
// - Counting starts at very first clock
// - Mismatch keeps clocking until wraparound match
// - Done open drain, pull-up default on
// - Preamble 0010 then 24-bit length
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cfgsu_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Configuration link pins
   input wire logic config_clock,
   input wire logic cfgData,
   input wire logic initHigh,
   // Start-up clock from user logic
   input wire logic user_startup_clock,
   // Done-status open-drain pin
   input wire logic doneIn,
   output logic doneOut,
   output logic doneOe_b,
   output logic donePullup,
   // Start-up results
   output logic ioActive,
   output logic global_set_reset,
   output logic configComplete,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   logic cclkS;
   logic dataS;
   logic initS;
   logic uclkS;
   logic doneS;
   logic [31:0] ctrlReg;
   logic clearPulse;
   logic config_clock_ff;
   logic uclk_ff;
   logic cclkRise;
   logic uclkRise;
   logic stepClk;
   logic userSel;
   logic syncSel;
   logic memFull;
   cfgsu_pkg::cfgsu_hdr_t hdr_ff;
   logic [3:0] pre_ff;
   logic [4:0] lenBits_ff;
   logic [cfgsu_pkg::LEN_BITS-1:0] length_ff;
   logic [cfgsu_pkg::LEN_BITS-1:0] count_ff;
   logic [cfgsu_pkg::STAGE_COUNT-1:0] stage_ff;
   logic startCond;
   logic doneRel_ff;
   logic [1:0] doneClks_ff;
   logic [31:0] statusVal;

   // Pin synchronisers
   cfgsu_sync uSyncCclk (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .asyncIn(config_clock),
      .syncOut(cclkS)
   );
   cfgsu_sync uSyncData (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .asyncIn(cfgData),
      .syncOut(dataS)
   );
   cfgsu_sync uSyncInit (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .asyncIn(initHigh),
      .syncOut(initS)
   );
   cfgsu_sync uSyncUclk (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .asyncIn(user_startup_clock),
      .syncOut(uclkS)
   );
   cfgsu_sync uSyncDone (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .asyncIn(doneIn),
      .syncOut(doneS)
   );

   cfgsu_axil uRegs (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .ctrlReg(ctrlReg),
      .clearPulse(clearPulse),
      .statusVal(statusVal),
      .lengthVal({8'h00, length_ff}),
      .countVal({8'h00, count_ff})
   );

   // Event selection: a 2-bit field names stage 1..4 (0 means stage 4)
   function automatic logic stageTap(input logic [cfgsu_pkg::STAGE_COUNT-1:0] st, input logic [1:0] sel);
      logic r;
      r = st[4];
      unique case (sel)
         2'd1: r = st[1];
         2'd2: r = st[2];
         2'd3: r = st[3];
         2'd0: r = st[4];
      endcase
      return r;
   endfunction : stageTap

   assign userSel = ctrlReg[cfgsu_pkg::CTRL_CLK_SEL];
   assign syncSel = ctrlReg[cfgsu_pkg::CTRL_DONE_SYNC];
   assign memFull = ctrlReg[cfgsu_pkg::CTRL_MEM_FULL];

   // Edge detection on settled clocks
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         config_clock_ff <= 1'b0;
         uclk_ff <= 1'b0;
      end else begin
         config_clock_ff <= cclkS;
         uclk_ff <= uclkS;
      end
   end
   assign cclkRise = cclkS && !config_clock_ff;
   assign uclkRise = uclkS && !uclk_ff;
   assign stepClk = userSel ? uclkRise : cclkRise;

   // Header parser and clock counter
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hdr_ff <= cfgsu_pkg::CFGSU_HUNT;
         pre_ff <= 4'hf;
         lenBits_ff <= 5'h00;
         length_ff <= '0;
         count_ff <= '0;
      end else if (clearPulse || !initS) begin
         hdr_ff <= cfgsu_pkg::CFGSU_HUNT;
         pre_ff <= 4'hf;
         lenBits_ff <= 5'h00;
         count_ff <= '0;
      end else if (cclkRise && !stage_ff[0]) begin
         count_ff <= count_ff + 1'b1;
         unique case (hdr_ff)
            cfgsu_pkg::CFGSU_HUNT: begin
               pre_ff <= {pre_ff[2:0], dataS};
               if ({pre_ff[2:0], dataS} == cfgsu_pkg::PREAMBLE_CODE) begin
                  hdr_ff <= cfgsu_pkg::CFGSU_LEN;
               end
            end
            cfgsu_pkg::CFGSU_LEN: begin
               length_ff <= {length_ff[cfgsu_pkg::LEN_BITS-2:0], dataS};
               lenBits_ff <= lenBits_ff + 1'b1;
               if (lenBits_ff == 5'(cfgsu_pkg::LEN_BITS - 1)) begin
                  hdr_ff <= cfgsu_pkg::CFGSU_DATA;
               end
            end
            cfgsu_pkg::CFGSU_DATA: begin
               hdr_ff <= cfgsu_pkg::CFGSU_DATA;
            end
            default: hdr_ff <= cfgsu_pkg::CFGSU_HUNT;
         endcase
      end
   end

   assign startCond = memFull && hdr_ff == cfgsu_pkg::CFGSU_DATA && count_ff == length_ff;

   // Five-stage start-up shift register; stages are sticky until clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_ff <= '0;
      end else begin
         if (clearPulse) begin
            stage_ff <= '0;
         end
         if (cclkRise && startCond) begin
            stage_ff[0] <= 1'b1;
         end
         if (cclkRise && stage_ff[0]) begin
            stage_ff[1] <= 1'b1;
         end
         if (userSel && uclkRise && stage_ff[1]) begin
            stage_ff[2] <= 1'b1;
         end else if (!userSel && cclkRise && stage_ff[1]) begin
            stage_ff[2] <= 1'b1;
         end
         if (stepClk && stage_ff[2] && (!syncSel || doneS)) begin
            stage_ff[3] <= 1'b1;
         end
         if (stepClk && stage_ff[3]) begin
            stage_ff[4] <= 1'b1;
         end
      end
   end

   // Event outputs and pin drive
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         doneRel_ff <= 1'b0;
         ioActive <= 1'b0;
         global_set_reset <= 1'b1;
         doneOut <= 1'b0;
         doneOe_b <= 1'b0;
         donePullup <= 1'b1;
      end else begin
         doneRel_ff <= stageTap(stage_ff, ctrlReg[cfgsu_pkg::CTRL_DONE_SEL +: 2]);
         ioActive <= stageTap(stage_ff, ctrlReg[cfgsu_pkg::CTRL_IO_SEL +: 2]);
         global_set_reset <= !stageTap(stage_ff, ctrlReg[cfgsu_pkg::CTRL_GSR_SEL +: 2]);
         doneOut <= 1'b0;
         doneOe_b <= stageTap(stage_ff, ctrlReg[cfgsu_pkg::CTRL_DONE_SEL +: 2]);
         donePullup <= ctrlReg[cfgsu_pkg::CTRL_PULLUP];
      end
   end

   // Completion: three start-up clocks after done released and pin high
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         doneClks_ff <= 2'd0;
         configComplete <= 1'b0;
      end else begin
         if (clearPulse) begin
            doneClks_ff <= 2'd0;
            configComplete <= 1'b0;
         end
         if (stepClk && doneRel_ff && doneS && !configComplete) begin
            if (doneClks_ff == 2'(cfgsu_pkg::COMPLETE_CYCLES - 1)) begin
               configComplete <= 1'b1;
            end else begin
               doneClks_ff <= doneClks_ff + 1'b1;
            end
         end
      end
   end

   assign statusVal = {21'h0, configComplete, global_set_reset, ioActive, doneS, hdr_ff, stage_ff};

   // Checks
   stage_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[1]) |-> $past(stage_ff[0]))
      else $error("Stage 1 rose without stage 0");
   start_cond_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[0]) |-> $past(startCond && cclkRise))
      else $error("Start without match");
   done_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[3]) && $past(syncSel) |-> $past(doneS))
      else $error("Stage 3 advanced with done low");
   user_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[2]) |-> $past(userSel ? uclkRise : cclkRise))
      else $error("Stage 2 used wrong clock");
   sticky_stage_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(stage_ff[0]) |-> $past(clearPulse))
      else $error("Stage dropped without clear");
   io_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[2]) && ctrlReg[9:8] == 2'd2 |=> ioActive)
      else $error("Io not released after stage 2");
   gsr_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[3]) && ctrlReg[13:12] == 2'd3 |=> !global_set_reset)
      else $error("Reset not released after stage 3");
   complete_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(configComplete) |-> $past(doneRel_ff && doneS))
      else $error("Complete before done high");
   count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cclkRise && initS && !clearPulse && !stage_ff[0] |=> count_ff == $past(count_ff) + 24'h1)
      else $error("Clock count did not step");
   stage1_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[1]) |-> $past(cclkRise))
      else $error("Stage 1 moved off the config clock");
   stage4_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(stage_ff[4]) |-> $past(stepClk) && $past(stage_ff[3]))
      else $error("Stage 4 set without a step");
   free_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      stepClk && stage_ff[2] && !syncSel |=> stage_ff[3])
      else $error("Free mode stage 3 did not step");
   stall_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      syncSel && !doneS && !stage_ff[3] |=> !stage_ff[3])
      else $error("Stage 3 set while done held low");
   count_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      stage_ff[0] && initS && !clearPulse |=> $stable(count_ff))
      else $error("Clock count moved after start");
   pullup_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> donePullup == $past(ctrlReg[cfgsu_pkg::CTRL_PULLUP]))
      else $error("Pull-up enable not following control");
   preamble_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      hdr_ff == cfgsu_pkg::CFGSU_HUNT && cclkRise && initS && !clearPulse && !stage_ff[0]
      && {pre_ff[2:0], dataS} == cfgsu_pkg::PREAMBLE_CODE |=> hdr_ff == cfgsu_pkg::CFGSU_LEN)
      else $error("Preamble not recognised");
   len_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      hdr_ff == cfgsu_pkg::CFGSU_LEN && lenBits_ff == 5'(cfgsu_pkg::LEN_BITS - 1) && cclkRise && initS
      && !clearPulse && !stage_ff[0] |=> hdr_ff == cfgsu_pkg::CFGSU_DATA)
      else $error("Length field did not end");
   start_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(stage_ff[0]));
   io_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(ioActive));
   stall_c: cover property (@(posedge ref_clk) disable iff (!rst_b) syncSel && stage_ff[2] && !doneS);
   done_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(configComplete));
   user_c: cover property (@(posedge ref_clk) disable iff (!rst_b) userSel && $rose(stage_ff[2]));
endmodule : cfgsu_top
`default_nettype wire

//--- shared/cfgsu_pkg.sv
// Constants and types for the configuration start-up sequencer
package cfgsu_pkg;
   // Preamble and length count framing
   localparam logic [3:0] PREAMBLE_CODE = 4'h2;
   localparam int LEN_BITS = 24;
   localparam int STAGE_COUNT = 5;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LENGTH = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0c;
   // Control field positions
   localparam int CTRL_CLK_SEL = 0;
   localparam int CTRL_DONE_SYNC = 1;
   localparam int CTRL_PULLUP = 2;
   localparam int CTRL_DONE_SEL = 4;
   localparam int CTRL_IO_SEL = 8;
   localparam int CTRL_GSR_SEL = 12;
   localparam int CTRL_MEM_FULL = 16;
   localparam int CTRL_CLEAR = 17;
   // Control reset: config clock, free running, pull-up on, done at stage 1, io at 2, gsr at 3
   localparam logic [31:0] CTRL_RESET = 32'h0000_3214;
   // Start-up clock count after done high at which configuration counts as complete
   localparam int COMPLETE_CYCLES = 3;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Header parser states
   typedef enum logic [1:0] {
      CFGSU_HUNT = 2'b00,
      CFGSU_LEN = 2'b01,
      CFGSU_DATA = 2'b11
   } cfgsu_hdr_t;
endpackage : cfgsu_pkg

//--- core/cfgsu_sync.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module cfgsu_sync (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Async level in, settled level out
   input wire logic asyncIn,
   output logic syncOut
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= asyncIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         syncOut <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         syncOut <= s3_ff;
      end
   end
endmodule : cfgsu_sync
`default_nettype wire

//--- core/cfgsu_axil.sv
// AXI4-Lite slave for the sequencer registers
`timescale 1ns/1ps
`default_nettype none
module cfgsu_axil (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic [31:0] ctrlReg,
   output logic clearPulse,
   input wire logic [31:0] statusVal,
   input wire logic [31:0] lengthVal,
   input wire logic [31:0] countVal
);
   logic [7:0] wAddr_ff;
   logic haveAw_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic haveW_ff;
   logic doWrite;
   assign doWrite = haveAw_ff && haveW_ff && !bvalid;
   assign awready = !haveAw_ff;
   assign wready = !haveW_ff;
   assign arready = !rvalid;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         haveAw_ff <= 1'b0;
         haveW_ff <= 1'b0;
         wAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
      end else begin
         if (awvalid && !haveAw_ff) begin
            haveAw_ff <= 1'b1;
            wAddr_ff <= awaddr;
         end else if (doWrite) begin
            haveAw_ff <= 1'b0;
         end
         if (wvalid && !haveW_ff) begin
            haveW_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
         end else if (doWrite) begin
            haveW_ff <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrlReg <= cfgsu_pkg::CTRL_RESET;
         clearPulse <= 1'b0;
         bvalid <= 1'b0;
         bresp <= cfgsu_pkg::RESP_OKAY;
      end else begin
         clearPulse <= 1'b0;
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= cfgsu_pkg::RESP_OKAY;
            if (wAddr_ff == cfgsu_pkg::REG_CTRL) begin
               for (int i = 0; i < 4; i++) begin
                  if (wStrb_ff[i]) begin
                     ctrlReg[i*8 +: 8] <= wData_ff[i*8 +: 8];
                  end
               end
               clearPulse <= wStrb_ff[2] && wData_ff[cfgsu_pkg::CTRL_CLEAR];
            end else if (wAddr_ff != cfgsu_pkg::REG_STATUS && wAddr_ff != cfgsu_pkg::REG_LENGTH
                         && wAddr_ff != cfgsu_pkg::REG_COUNT) begin
               bresp <= cfgsu_pkg::RESP_SLVERR;
            end
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= cfgsu_pkg::RESP_OKAY;
      end else if (rvalid) begin
         if (rready) begin
            rvalid <= 1'b0;
         end
      end else if (arvalid) begin
         rvalid <= 1'b1;
         rresp <= cfgsu_pkg::RESP_OKAY;
         unique case (araddr)
            cfgsu_pkg::REG_CTRL: rdata <= ctrlReg & 32'h0000_ffff;
            cfgsu_pkg::REG_STATUS: rdata <= statusVal;
            cfgsu_pkg::REG_LENGTH: rdata <= lengthVal;
            cfgsu_pkg::REG_COUNT: rdata <= countVal;
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= cfgsu_pkg::RESP_SLVERR;
            end
         endcase
      end
   end
endmodule : cfgsu_axil
`default_nettype wire

//--- dv/cfgsu_source.sv
// Model of the configuration data source and the board logic on the done pin
`timescale 1ns/1ps
`default_nettype none
module cfgsu_source (
   // Clock
   input wire logic ref_clk,
   // Done pin drivers and board hold
   input wire logic doneOut,
   input wire logic doneOe_b,
   input wire logic donePullup,
   input wire logic holdLow,
   // Link pins
   output logic config_clock,
   output logic cfgData,
   output logic initHigh,
   output logic user_startup_clock,
   output logic doneIn
);
   // Wired-AND pin, high only when released and pulled up
   assign doneIn = (doneOe_b ? donePullup : doneOut) & !holdLow;
   initial begin
      config_clock = 1'b0;
      cfgData = 1'b1;
      initHigh = 1'b0;
      user_startup_clock = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   // One config clock, data set ahead of the rise; clock stands still after
   task automatic cpulse(input logic b);
      wt(1);
      cfgData <= b;
      wt(2);
      config_clock <= 1'b1;
      wt(6);
      config_clock <= 1'b0;
      wt(4);
   endtask : cpulse
   task automatic ones(input int n);
      repeat (n) cpulse(1'b1);
   endtask : ones
   // Preamble then length, msb first
   task automatic header(input logic [23:0] len);
      logic [27:0] h;
      h = {4'h2, len};
      for (int i = 27; i >= 0; i--) begin
         cpulse(h[i]);
      end
   endtask : header
   task automatic upulse(input int n);
      repeat (n) begin
         wt(2);
         user_startup_clock <= 1'b1;
         wt(6);
         user_startup_clock <= 1'b0;
         wt(4);
      end
   endtask : upulse
   // Counting restarts from the first clock after init goes high
   task automatic restart();
      initHigh <= 1'b0;
      wt(8);
      initHigh <= 1'b1;
      wt(8);
   endtask : restart
endmodule : cfgsu_source
`default_nettype wire

//--- dv/tb_top.sv
// Testbench for the configuration start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk, rst_b, holdLow;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic config_clock, cfgData, initHigh, user_startup_clock, doneIn;
   logic doneOut, doneOe_b, donePullup, ioActive, global_set_reset, configComplete;
   logic [5:0] pins;
   int errors, comparisons;
   localparam int LEN = 40;
   assign pins = {doneOut, donePullup, doneOe_b, ioActive, global_set_reset, configComplete};
   cfgsu_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .config_clock(config_clock), .cfgData(cfgData),
      .initHigh(initHigh), .user_startup_clock(user_startup_clock), .doneIn(doneIn), .doneOut(doneOut),
      .doneOe_b(doneOe_b), .donePullup(donePullup), .ioActive(ioActive), .global_set_reset(global_set_reset),
      .configComplete(configComplete), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   cfgsu_source src (.ref_clk(ref_clk), .doneOut(doneOut), .doneOe_b(doneOe_b), .donePullup(donePullup),
      .holdLow(holdLow), .config_clock(config_clock), .cfgData(cfgData), .initHigh(initHigh),
      .user_startup_clock(user_startup_clock), .doneIn(doneIn));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic test_done();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkp(input logic [5:0] e);
      chk({26'h0, pins}, {26'h0, e});
   endtask : chkp
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er, input logic [3:0] s = 4'hf);
      logic sa, sw, sb;
      logic [1:0] r;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      sb = 1'b0;
      for (int n = 0; n < 50 && !sb; n++) begin
         @(negedge ref_clk);
         sa = awvalid && awready === 1'b1;
         sw = wvalid && wready === 1'b1;
         sb = bvalid === 1'b1;
         r = bresp;
         @(posedge ref_clk);
         if (sa) awvalid <= 1'b0;
         if (sw) wvalid <= 1'b0;
         if (sb) bready <= 1'b0;
      end
      if (!sb) begin
         errors++;
         test_done();
      end
      chk({30'h0, r}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      logic sr;
      logic [1:0] r;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      sr = 1'b0;
      for (int n = 0; n < 50 && !sr; n++) begin
         @(negedge ref_clk);
         sr = rvalid === 1'b1;
         r = rresp;
         v = rdata;
         if (arready === 1'b1) @(posedge ref_clk) arvalid <= 1'b0;
         else @(posedge ref_clk);
         if (sr) rready <= 1'b0;
      end
      if (!sr) begin
         errors++;
         test_done();
      end
      chk({30'h0, r}, {30'h0, er});
   endtask : rd
   // Clear, restart link, program control, send header padded to the length
   task automatic prep(input logic [31:0] c);
      wr(cfgsu_pkg::REG_CTRL, 32'h0002_3214, cfgsu_pkg::RESP_OKAY);
      src.restart();
      wr(cfgsu_pkg::REG_CTRL, c, cfgsu_pkg::RESP_OKAY);
      src.header(24'(LEN));
      src.ones(LEN - 28);
   endtask : prep
   // One config clock per step, pins checked after each
   task automatic seq(input int n, input logic [29:0] e);
      for (int i = 0; i < n; i++) begin
         src.ones(1);
         chkp(e[29 - 6 * i -: 6]);
      end
   endtask : seq
   initial begin
      rst_b = 1'b0;
      holdLow = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      errors = 0;
      comparisons = 0;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      chkp(6'b010010);
      rd(cfgsu_pkg::REG_CTRL, d, cfgsu_pkg::RESP_OKAY);
      chk(d, cfgsu_pkg::CTRL_RESET);
      wr(cfgsu_pkg::REG_CTRL, 32'hffff_ff00, cfgsu_pkg::RESP_OKAY, 4'h1);
      rd(cfgsu_pkg::REG_CTRL, d, cfgsu_pkg::RESP_OKAY);
      chk(d, 32'h0000_3200);
      chkp(6'b000010);
      wr(cfgsu_pkg::REG_CTRL, cfgsu_pkg::CTRL_RESET, cfgsu_pkg::RESP_OKAY);
      rd(8'h10, d, cfgsu_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h10, 32'h0, cfgsu_pkg::RESP_SLVERR);
      wr(cfgsu_pkg::REG_STATUS, 32'hffff_ffff, cfgsu_pkg::RESP_OKAY);
      $display("test reset_bus done");
      src.restart();
      src.header(24'(LEN));
      src.ones(20);
      chkp(6'b010010);
      wr(cfgsu_pkg::REG_CTRL, 32'h0001_3214, cfgsu_pkg::RESP_OKAY);
      src.ones(4);
      chkp(6'b010010);
      rd(cfgsu_pkg::REG_COUNT, d, cfgsu_pkg::RESP_OKAY);
      chk(d, 32'd52);
      $display("test no_start done");
      prep(32'h0001_3214);
      rd(cfgsu_pkg::REG_LENGTH, d, cfgsu_pkg::RESP_OKAY);
      chk(d, 32'(LEN));
      chkp(6'b010010);
      seq(4, {6'b010010, 6'b011010, 6'b011110, 6'b011100, 6'h0});
      src.ones(3);
      chkp(6'b011101);
      src.ones(2);
      chkp(6'b011101);
      wr(cfgsu_pkg::REG_CTRL, 32'h0002_3214, cfgsu_pkg::RESP_OKAY);
      src.wt(4);
      chkp(6'b010010);
      $display("test default_order done");
      holdLow <= 1'b1;
      prep(32'h0001_1100);
      seq(5, {6'b000010, 6'b000100, 6'b000100, 6'b000100, 6'b001100});
      $display("test reorder done");
      prep(32'h0001_3217);
      seq(2, {6'b010010, 6'b011010, 18'h0});
      src.ones(3);
      chkp(6'b011010);
      src.upulse(4);
      chkp(6'b011110);
      holdLow <= 1'b0;
      src.upulse(4);
      chkp(6'b011101);
      $display("test user_sync done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
